/* design/fai_pkg.sv */
package fai_pkg;
    // ==========================================================
    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    // ==========================================================
    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_MODE = 8'h20;
    localparam logic [7:0] IDX_START_EN = 8'h22;
    localparam logic [7:0] IDX_END_EN = 8'h23;
    localparam logic [7:0] IDX_START_STAT = 8'h30;
    localparam logic [7:0] IDX_END_STAT = 8'h31;
    // ==========================================================
    // field layout
    localparam int START_W = 6;
    localparam int END_W = 5;
    localparam int BIT_OOF = 0;
    localparam int BIT_AIS = 1;
    localparam int BIT_REMOTE = 2;
    localparam int BIT_IDLE = 3;
    localparam int BIT_LOS = 4;
    localparam int BIT_SEF = 5;
    localparam int BIT_MODE_CBIT = 0;
    localparam int BIT_MODE_E3 = 1;
    localparam logic [7:0] START_EN_MASK = 8'h3F;
    localparam logic [7:0] END_EN_MASK = 8'h1F;
    localparam logic [7:0] MODE_MASK = 8'h03;
    // sources whose enable only counts in ds3 framing
    localparam logic [START_W-1:0] START_DS3_ONLY = 6'h28;
    localparam logic [END_W-1:0] END_DS3_ONLY = 5'h08;
    // ==========================================================
    // values after reset
    localparam logic [7:0] START_EN_RST = 8'h00;
    localparam logic [7:0] END_EN_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
endpackage

/* design/fai_flag_bank.sv */
`timescale 1ns/10ps
// ==============================================================
// sticky event flags with write-one-to-clear and enable gating
module fai_flag_bank
    import fai_pkg::*;
#(
    parameter int W = START_W
)
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [W-1:0] event_pulse,
    input wire logic [W-1:0] clear_mask,
    input wire logic [W-1:0] enable,
    input wire logic [W-1:0] mode_ok,
    output logic [W-1:0] flags,
    output logic [W-1:0] pending
);
    logic [W-1:0] flag_reg;
    logic [W-1:0] flag_next;

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_flag
            // a set in the clearing cycle wins so no event is lost
            assign flag_next[i] = event_pulse[i] | (flag_reg[i] & ~clear_mask[i]);
            // flag counts toward the interrupt only when enabled and mode allows
            assign pending[i] = flag_reg[i] & enable[i] & mode_ok[i];
        end
    endgenerate

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            flag_reg <= '0;
        else
            flag_reg <= flag_next;
    end

    assign flags = flag_reg;
endmodule

/* design/fai_top.sv */
`timescale 1ns/10ps
// ==============================================================
// alarm interrupt enables for one framer receiver
module fai_top
    import fai_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic sef_start_evt,
    input wire logic sig_loss_start_evt,
    input wire logic idle_start_evt,
    input wire logic remote_alarm_start_evt,
    input wire logic ais_start_evt,
    input wire logic out_of_frame_start_evt,
    input wire logic sig_loss_end_evt,
    input wire logic idle_end_evt,
    input wire logic remote_alarm_end_evt,
    input wire logic ais_end_evt,
    input wire logic out_of_frame_end_evt,
    input wire logic other_irq_req,
    output logic combined_interrupt_n
);
    // ==========================================================
    // bus slave: one wait cycle per access
    logic ack_reg;
    logic [DATA_W-1:0] rdata_reg;
    wire access_req = avs_read | avs_write;
    wire wr_commit = avs_write & ack_reg & avs_byteenable[0];
    wire sel_mode = (avs_address == IDX_MODE);
    wire sel_start_en = (avs_address == IDX_START_EN);
    wire sel_end_en = (avs_address == IDX_END_EN);
    wire sel_start_stat = (avs_address == IDX_START_STAT);
    wire sel_end_stat = (avs_address == IDX_END_STAT);
    wire [REG_W-1:0] wbyte = avs_writedata[REG_W-1:0];

    assign avs_waitrequest = access_req & ~ack_reg;

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            ack_reg <= 1'b0;
        else
            ack_reg <= access_req & ~ack_reg;
    end

    // ==========================================================
    // control registers
    logic [REG_W-1:0] mode_reg;
    logic [REG_W-1:0] start_en_reg;
    logic [REG_W-1:0] end_en_reg;
    // reserved bits are not stored, so they read back as zero
    wire [REG_W-1:0] mode_next = sel_mode & wr_commit ? (wbyte & MODE_MASK) : mode_reg;
    wire [REG_W-1:0] start_en_next =
        sel_start_en & wr_commit ? (wbyte & START_EN_MASK) : start_en_reg;
    wire [REG_W-1:0] end_en_next = sel_end_en & wr_commit ? (wbyte & END_EN_MASK) : end_en_reg;

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            mode_reg <= MODE_RST;
            start_en_reg <= START_EN_RST;
            end_en_reg <= END_EN_RST;
        end
        else
        begin
            mode_reg <= mode_next;
            start_en_reg <= start_en_next;
            end_en_reg <= end_en_next;
        end
    end

    // ==========================================================
    // framing mode decode
    wire is_e3 = mode_reg[BIT_MODE_E3];
    wire is_ds3 = ~is_e3;
    // ds3-only sources lose their enable in either e3 framing
    wire [START_W-1:0] start_mode_ok = is_ds3 ? {START_W{1'b1}} : ~START_DS3_ONLY;
    wire [END_W-1:0] end_mode_ok = is_ds3 ? {END_W{1'b1}} : ~END_DS3_ONLY;

    // ==========================================================
    // event collection, already on core_clk from the detectors
    logic [START_W-1:0] start_evt;
    logic [END_W-1:0] end_evt;
    assign start_evt[BIT_SEF] = sef_start_evt;
    assign start_evt[BIT_LOS] = sig_loss_start_evt;
    assign start_evt[BIT_IDLE] = idle_start_evt;
    assign start_evt[BIT_REMOTE] = remote_alarm_start_evt;
    assign start_evt[BIT_AIS] = ais_start_evt;
    assign start_evt[BIT_OOF] = out_of_frame_start_evt;
    assign end_evt[BIT_LOS] = sig_loss_end_evt;
    assign end_evt[BIT_IDLE] = idle_end_evt;
    assign end_evt[BIT_REMOTE] = remote_alarm_end_evt;
    assign end_evt[BIT_AIS] = ais_end_evt;
    assign end_evt[BIT_OOF] = out_of_frame_end_evt;

    // status clear: write one to clear, only on the committing edge
    wire [START_W-1:0] start_clr = (sel_start_stat & wr_commit) ? wbyte[START_W-1:0] : '0;
    wire [END_W-1:0] end_clr = (sel_end_stat & wr_commit) ? wbyte[END_W-1:0] : '0;

    logic [START_W-1:0] start_flags;
    logic [START_W-1:0] start_pending;
    logic [END_W-1:0] end_flags;
    logic [END_W-1:0] end_pending;

    fai_flag_bank #(
        .W(START_W)
    ) u_start_bank (
        .core_clk(core_clk),
        .rstn(rstn),
        .event_pulse(start_evt),
        .clear_mask(start_clr),
        .enable(start_en_reg[START_W-1:0]),
        .mode_ok(start_mode_ok),
        .flags(start_flags),
        .pending(start_pending)
    );

    fai_flag_bank #(
        .W(END_W)
    ) u_end_bank (
        .core_clk(core_clk),
        .rstn(rstn),
        .event_pulse(end_evt),
        .clear_mask(end_clr),
        .enable(end_en_reg[END_W-1:0]),
        .mode_ok(end_mode_ok),
        .flags(end_flags),
        .pending(end_pending)
    );

    // ==========================================================
    // read mux
    wire [REG_W-1:0] rd_byte =
        sel_mode ? mode_reg :
        sel_start_en ? start_en_reg :
        sel_end_en ? end_en_reg :
        sel_start_stat ? {{(REG_W-START_W){1'b0}}, start_flags} :
        sel_end_stat ? {{(REG_W-END_W){1'b0}}, end_flags} :
        8'h00;
    // captured in the wait cycle so it stands at the ready edge
    wire [DATA_W-1:0] rdata_next =
        (avs_read & ~ack_reg) ? {{(DATA_W-REG_W){1'b0}}, rd_byte} : rdata_reg;

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            rdata_reg <= '0;
        else
            rdata_reg <= rdata_next;
    end

    assign avs_readdata = rdata_reg;

    // ==========================================================
    // combined interrupt, registered to keep the pin glitch free
    logic irq_n_reg;
    wire any_pending = (|start_pending) | (|end_pending) | other_irq_req;
    wire irq_n_next = ~any_pending;

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            irq_n_reg <= 1'b1;
        else
            irq_n_reg <= irq_n_next;
    end

    assign combined_interrupt_n = irq_n_reg;

    // ==========================================================
    // checks
    sequence s_sef_armed;
        sef_start_evt && start_en_reg[BIT_SEF] && is_ds3;
    endsequence

    sequence s_sef_still_armed;
        start_en_reg[BIT_SEF] && is_ds3;
    endsequence

    property p_sef_irq;
        @(posedge core_clk) disable iff (!rstn)
        s_sef_armed ##1 s_sef_still_armed |=> !combined_interrupt_n;
    endproperty
    a_sef_irq: assert property (p_sef_irq) else $error("sef start did not raise irq");

    property p_sef_flag;
        @(posedge core_clk) disable iff (!rstn)
        sef_start_evt |=> start_flags[BIT_SEF];
    endproperty
    a_sef_flag: assert property (p_sef_flag) else $error("sef start flag not set");

    property p_e3_ds3_only_quiet;
        @(posedge core_clk) disable iff (!rstn)
        (is_e3 && !other_irq_req
            && ((start_flags & start_en_reg[START_W-1:0] & ~START_DS3_ONLY) == '0)
            && ((end_flags & end_en_reg[END_W-1:0] & ~END_DS3_ONLY) == '0))
        |=> combined_interrupt_n;
    endproperty
    a_e3_ds3_only_quiet: assert property (p_e3_ds3_only_quiet)
        else $error("ds3-only source raised irq in e3 mode");

    property p_los_irq;
        @(posedge core_clk) disable iff (!rstn)
        (start_flags[BIT_LOS] && start_en_reg[BIT_LOS]) |=> !combined_interrupt_n;
    endproperty
    a_los_irq: assert property (p_los_irq) else $error("los start did not raise irq");

    property p_los_flag;
        @(posedge core_clk) disable iff (!rstn)
        sig_loss_start_evt |=> start_flags[BIT_LOS];
    endproperty
    a_los_flag: assert property (p_los_flag) else $error("los start flag not set");

    property p_remote_start;
        @(posedge core_clk) disable iff (!rstn)
        (remote_alarm_start_evt && start_en_reg[BIT_REMOTE])
        |=> start_flags[BIT_REMOTE] && start_pending[BIT_REMOTE];
    endproperty
    a_remote_start: assert property (p_remote_start)
        else $error("remote alarm start not pending");

    property p_ais_start_irq;
        @(posedge core_clk) disable iff (!rstn)
        (start_flags[BIT_AIS] && start_en_reg[BIT_AIS]) |=> !combined_interrupt_n;
    endproperty
    a_ais_start_irq: assert property (p_ais_start_irq) else $error("ais start no irq");

    property p_ais_start_flag;
        @(posedge core_clk) disable iff (!rstn)
        ais_start_evt |=> start_flags[BIT_AIS];
    endproperty
    a_ais_start_flag: assert property (p_ais_start_flag) else $error("ais start flag");

    property p_los_end_irq;
        @(posedge core_clk) disable iff (!rstn)
        (end_flags[BIT_LOS] && end_en_reg[BIT_LOS]) |=> !combined_interrupt_n;
    endproperty
    a_los_end_irq: assert property (p_los_end_irq) else $error("los end no irq");

    property p_los_end_flag;
        @(posedge core_clk) disable iff (!rstn)
        sig_loss_end_evt |=> end_flags[BIT_LOS];
    endproperty
    a_los_end_flag: assert property (p_los_end_flag) else $error("los end flag");

    property p_idle_end_irq;
        @(posedge core_clk) disable iff (!rstn)
        (end_flags[BIT_IDLE] && end_en_reg[BIT_IDLE] && is_ds3) |=> !combined_interrupt_n;
    endproperty
    a_idle_end_irq: assert property (p_idle_end_irq) else $error("idle end no irq");

    property p_idle_end_flag;
        @(posedge core_clk) disable iff (!rstn)
        idle_end_evt |=> end_flags[BIT_IDLE];
    endproperty
    a_idle_end_flag: assert property (p_idle_end_flag) else $error("idle end flag");

    property p_remote_end;
        @(posedge core_clk) disable iff (!rstn)
        (remote_alarm_end_evt && end_en_reg[BIT_REMOTE])
        |=> end_flags[BIT_REMOTE] ##1 !combined_interrupt_n;
    endproperty
    a_remote_end: assert property (p_remote_end)
        else $error("remote alarm end not raised");

    property p_ais_end_irq;
        @(posedge core_clk) disable iff (!rstn)
        (end_flags[BIT_AIS] && end_en_reg[BIT_AIS]) |=> !combined_interrupt_n;
    endproperty
    a_ais_end_irq: assert property (p_ais_end_irq) else $error("ais end no irq");

    property p_ais_end_flag;
        @(posedge core_clk) disable iff (!rstn)
        ais_end_evt |=> end_flags[BIT_AIS];
    endproperty
    a_ais_end_flag: assert property (p_ais_end_flag) else $error("ais end flag");

    property p_end_en_reset;
        @(posedge core_clk) disable iff (!rstn)
        $rose(rstn) |-> (end_en_reg == END_EN_RST);
    endproperty
    a_end_en_reset: assert property (p_end_en_reset) else $error("end enable not reset");

    property p_oof_flags;
        @(posedge core_clk) disable iff (!rstn)
        out_of_frame_start_evt |=> start_flags[BIT_OOF];
    endproperty
    a_oof_flags: assert property (p_oof_flags) else $error("oof flags not set");

    property p_oof_end_flag;
        @(posedge core_clk) disable iff (!rstn)
        out_of_frame_end_evt |=> end_flags[BIT_OOF];
    endproperty
    a_oof_end_flag: assert property (p_oof_end_flag) else $error("oof end flag");

    property p_idle_start_e3;
        @(posedge core_clk) disable iff (!rstn)
        is_e3 |-> !start_pending[BIT_IDLE];
    endproperty
    a_idle_start_e3: assert property (p_idle_start_e3) else $error("idle start in e3");

    property p_irq_idle;
        @(posedge core_clk) disable iff (!rstn)
        (start_pending == '0 && end_pending == '0 && !other_irq_req) |=> combined_interrupt_n;
    endproperty
    a_irq_idle: assert property (p_irq_idle) else $error("irq without source");

    property p_wr_start_en;
        @(posedge core_clk) disable iff (!rstn)
        (sel_start_en && wr_commit) |=> (start_en_reg == ($past(wbyte) & START_EN_MASK));
    endproperty
    a_wr_start_en: assert property (p_wr_start_en) else $error("start enable write lost");
endmodule

/* tb/framer_alarm_interrupt_enables_tb.sv */
`timescale 1ns/10ps
// ==============================================================
// bench for the alarm interrupt enables
module framer_alarm_interrupt_enables_tb
    import fai_pkg::*;
;
    logic core_clk;
    logic rstn;
    logic [ADDR_W-1:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [DATA_W-1:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic [START_W-1:0] st_evt;
    logic [END_W-1:0] end_evt;
    logic other_irq_req;
    logic combined_interrupt_n;
    int num_errors;
    int cmp_count;
    int m;
    int s;
    int b;
    logic is_end;
    logic ds3_only;
    logic exp_n;
    logic [7:0] en_idx;
    logic [7:0] st_idx;
    logic [31:0] bit_val;
    logic [31:0] rd;

    fai_top i_dut (
        .core_clk(core_clk),
        .rstn(rstn),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .sef_start_evt(st_evt[BIT_SEF]),
        .sig_loss_start_evt(st_evt[BIT_LOS]),
        .idle_start_evt(st_evt[BIT_IDLE]),
        .remote_alarm_start_evt(st_evt[BIT_REMOTE]),
        .ais_start_evt(st_evt[BIT_AIS]),
        .out_of_frame_start_evt(st_evt[BIT_OOF]),
        .sig_loss_end_evt(end_evt[BIT_LOS]),
        .idle_end_evt(end_evt[BIT_IDLE]),
        .remote_alarm_end_evt(end_evt[BIT_REMOTE]),
        .ais_end_evt(end_evt[BIT_AIS]),
        .out_of_frame_end_evt(end_evt[BIT_OOF]),
        .other_irq_req(other_irq_req),
        .combined_interrupt_n(combined_interrupt_n)
    );

    always #20 core_clk = ~core_clk;

    // ==========================================================
    // bus tasks and comparison
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask

    // request held until waitrequest is sampled low at a rising edge
    task automatic bus_cycle(input logic wr, input logic [7:0] a, input logic [31:0] d,
                             input logic [3:0] be, output logic [31:0] q);
        int n;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= ~wr;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 64);
        if (n >= 64)
        begin
            $display("Error at %0t: got %h expected %h", $time, 32'h1, 32'h0);
            num_errors++;
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus_cycle(1'b1, a, d, 4'hF, q);
    endtask

    task automatic read_check(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus_cycle(1'b0, a, 32'h0, 4'hF, q);
        check(q, exp);
    endtask

    // output sampled mid-cycle, one cycle after the launching edge
    task automatic settle();
        @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task automatic irq_check(input logic exp);
        check({31'h0, combined_interrupt_n}, {31'h0, exp});
    endtask

    // one-cycle event pulse; returns in the cycle where the interrupt must show
    task automatic pulse();
        @(posedge core_clk);
        if (is_end)
            end_evt[b] <= 1'b1;
        else
            st_evt[b] <= 1'b1;
        @(posedge core_clk);
        st_evt <= '0;
        end_evt <= '0;
        settle();
    endtask

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ==========================================================
    // watchdog
    initial
    begin
        repeat (40000) @(posedge core_clk);
        num_errors++;
        give_verdict();
    end

    // ==========================================================
    // main sequence
    initial
    begin
        core_clk = 1'b0;
        rstn = 1'b0;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = 4'h0;
        st_evt = '0;
        end_evt = '0;
        other_irq_req = 1'b0;
        num_errors = 0;
        cmp_count = 0;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        settle();
        irq_check(1'b1);
        read_check(IDX_START_EN, 32'h0);
        read_check(IDX_END_EN, 32'h0);
        read_check(8'h21, 32'h0);
        bus_write(8'h21, 32'h0000_003F);
        read_check(8'h21, 32'h0);
        bus_write(IDX_END_EN, 32'h0000_001F);
        read_check(IDX_END_EN, 32'h0000_001F);
        bus_cycle(1'b1, IDX_END_EN, 32'h0, 4'h0, rd);
        read_check(IDX_END_EN, 32'h0000_001F);
        bus_write(IDX_END_EN, 32'h0);
        bus_write(IDX_START_EN, 32'h0000_003F);
        read_check(IDX_START_EN, 32'h0000_003F);
        bus_write(IDX_START_EN, 32'h0);
        @(posedge core_clk);
        other_irq_req <= 1'b1;
        settle();
        irq_check(1'b0);
        @(posedge core_clk);
        other_irq_req <= 1'b0;
        settle();
        irq_check(1'b1);
        // every source in every framing mode, enable off then on
        for (m = 0; m < 4; m++)
        begin
            bus_write(IDX_MODE, m);
            for (s = 0; s < START_W + END_W; s++)
            begin
                is_end = (s >= START_W);
                b = is_end ? s - START_W : s;
                en_idx = is_end ? IDX_END_EN : IDX_START_EN;
                st_idx = is_end ? IDX_END_STAT : IDX_START_STAT;
                bit_val = 32'h1 << b;
                ds3_only = (b == BIT_IDLE) || (!is_end && b == BIT_SEF);
                exp_n = ds3_only && m >= 2;
                pulse();
                irq_check(1'b1);
                read_check(st_idx, bit_val);
                bus_write(en_idx, bit_val);
                settle();
                irq_check(exp_n);
                bus_write(st_idx, bit_val);
                settle();
                irq_check(1'b1);
                read_check(st_idx, 32'h0);
                pulse();
                irq_check(exp_n);
                read_check(st_idx, bit_val);
                bus_write(en_idx, 32'h0);
                settle();
                irq_check(1'b1);
                bus_write(st_idx, bit_val);
                read_check(st_idx, 32'h0);
            end
        end
        give_verdict();
    end
endmodule
